// file: core/crp_command_handler.sv
// Text command handler for a small audio/video crosspoint with one output
// Notes on behaviour
// - Switch connects input to output, echoes numbers
// - Input zero disconnects the output layer
// - Switch reply carries no mute indication
// - AV from analog video takes matching audio
// - Mute disables output, keeps selection, replies
// - Switching a muted output keeps it muted
// - Unmute restores stored selection, replies
// - Missing layer means audio and video, except switch and autoselect reject it
// - Lock sets flag, rejects changes until unlock
// - Unlock clears and replies even while locked, given a valid output number
// - State query: one line per layer
// - State letters L, M, or U
// - Size query reports 6x1 video, 5x1 audio
// - Autoselect query returns state;mode
// - Letters E/D and F/L/P encode autoselect
// - Curly commands, round replies, only on success
// - Command characters folded to uppercase
// - Every reply line ends CR LF
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "crp_defs.svh"

module crp_command_handler
  import crp_pkg::*;
(
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output var  logic [31:0]  prdata,
  output var  logic         pready,
  output var  logic         pslverr,
  // Command byte stream in
  input  wire logic [7:0]   rx_data,
  input  wire logic         rx_valid,
  output var  logic         rx_ready,
  // Reply byte stream out
  output var  logic [7:0]   tx_data,
  output var  logic         tx_valid,
  input  wire logic         tx_ready,
  // Crosspoint controls
  output var  logic [2:0]   vid_sel,
  output var  logic         vid_active,
  output var  logic [2:0]   aud_sel,
  output var  logic         aud_active
);

  // Controller state
  crp_state_t                state;
  crp_state_t                next_state;
  // Parsed command fields
  crp_kind_t                 kind;
  logic [6:0]                num_in;
  logic [6:0]                num_out;
  logic [1:0]                nd_in;
  logic [1:0]                nd_out;
  logic                      lay_a;
  logic                      lay_v;
  logic                      lay_field;
  logic                      got_at;
  logic                      got_q;
  logic                      perr;
  // Per layer crosspoint state
  logic                      v_mute;
  logic                      v_lock;
  logic                      a_mute;
  logic                      a_lock;
  // Software settings
  logic                      ctrl_en;
  logic [`CRP_AS_WIDTH-1:0]  autosel;
  logic [15:0]               rejects;
  // Reply sequencing
  logic                      pend_v;
  logic                      pend_a;
  logic [`CRP_LINE_AW-1:0]   wi;
  logic [`CRP_LINE_AW-1:0]   ri;
  logic [7:0]                mem_rd;
  // Helpers
  logic [7:0]                c_up;
  logic                      is_dig;
  logic [3:0]                dig;
  logic                      rx_fire;
  logic                      no_lay;
  logic                      eff_a;
  logic                      eff_v;
  logic                      lock_hit;
  logic                      out_ok;
  logic                      cmd_ok;
  logic                      exec_ok;
  logic [`CRP_LINE_BITS-1:0] acc;
  logic [4:0]                llen;
  logic [`CRP_LINE_AW-1:0]   last_idx;
  logic [7:0]                wr_char;
  logic                      line_done;
  logic                      apb_setup;
  logic                      apb_write;

  // Two ASCII digits of a small number
  function automatic logic [15:0] two_dig(input logic [6:0] n);
    return {`CRP_DIGIT_BASE + 8'(n / `CRP_TEN), `CRP_DIGIT_BASE + 8'(n % `CRP_TEN)};
  endfunction : two_dig

  // Incoming character folded to uppercase
  always_comb begin
    c_up = rx_data;
    if (rx_data >= "a" && rx_data <= "z") begin
      c_up = rx_data & ~`CRP_CASE_BIT;
    end
  end

  assign is_dig  = (c_up >= "0") && (c_up <= "9");
  assign dig     = 4'(c_up - `CRP_DIGIT_BASE);
  assign rx_fire = rx_valid && rx_ready;

  // Layer defaults and command validity
  assign no_lay   = !lay_a && !lay_v;
  assign eff_a    = no_lay ? 1'b1 : lay_a;
  assign eff_v    = no_lay ? 1'b1 : lay_v;
  assign lock_hit = (eff_a && a_lock) || (eff_v && v_lock);
  assign out_ok   = (nd_out != 2'd0) && (num_out == `CRP_OUT_NUM);

  always_comb begin
    case (kind)
      // Switch needs a layer and an input in range on every named layer
      K_SWITCH: cmd_ok = got_at && out_ok && !no_lay && !lock_hit && (!lay_v || num_in <= `CRP_VID_INPUTS)
                         && (!lay_a || num_in <= `CRP_AUD_INPUTS);
      K_MUTE,
      K_UNMUTE: cmd_ok = out_ok && !lock_hit;
      K_LOCK,
      K_UNLOCK: cmd_ok = out_ok;
      K_CQ,
      K_SIZE:   cmd_ok = 1'b1;
      // Autoselect query names exactly one layer
      K_AS:     cmd_ok = out_ok && got_q && (lay_a ^ lay_v);
      default:  cmd_ok = 1'b0;
    endcase
  end

  assign exec_ok = !perr && cmd_ok;

  // Next controller state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (rx_fire && ctrl_en && c_up == "{") begin
          next_state = ST_PARSE;
        end
      end
      ST_PARSE: begin
        if (rx_fire && c_up == "}") begin
          next_state = ST_EXEC;
        end
      end
      ST_EXEC:  next_state = exec_ok ? ST_BUILD : ST_IDLE;
      ST_BUILD: begin
        if (wi == last_idx) begin
          next_state = ST_READ;
        end
      end
      ST_READ:  next_state = ST_LOAD;
      ST_LOAD:  next_state = ST_SEND;
      ST_SEND: begin
        if (tx_ready && ri == last_idx) begin
          next_state = (pend_v && pend_a) ? ST_BUILD : ST_IDLE;
        end else if (tx_ready) begin
          next_state = ST_READ;
        end
      end
      default:  next_state = ST_IDLE;
    endcase
  end

  // State register and input stall
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state    <= ST_IDLE;
      rx_ready <= 1'b0;
    end else begin
      state    <= next_state;
      rx_ready <= (next_state == ST_IDLE) || (next_state == ST_PARSE);
    end
  end

  // Command parser, one character per accepted byte
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      kind      <= K_NONE;
      num_in    <= 7'h00;
      num_out   <= 7'h00;
      nd_in     <= 2'd0;
      nd_out    <= 2'd0;
      lay_a     <= 1'b0;
      lay_v     <= 1'b0;
      lay_field <= 1'b0;
      got_at    <= 1'b0;
      got_q     <= 1'b0;
      perr      <= 1'b0;
    end else if (rx_fire && (c_up == "{") && (state == ST_IDLE || state == ST_PARSE)) begin
      // Opening bracket starts a fresh command
      kind      <= K_NONE;
      num_in    <= 7'h00;
      num_out   <= 7'h00;
      nd_in     <= 2'd0;
      nd_out    <= 2'd0;
      lay_a     <= 1'b0;
      lay_v     <= 1'b0;
      lay_field <= 1'b0;
      got_at    <= 1'b0;
      got_q     <= 1'b0;
      perr      <= 1'b0;
    end else if (rx_fire && state == ST_PARSE && c_up != "}") begin
      if (kind == K_NONE) begin
        // First character picks the command kind
        if (is_dig) begin
          kind   <= K_SWITCH;
          num_in <= {3'd0, dig};
          nd_in  <= 2'd1;
        end else if (c_up == "#") begin
          kind <= K_MUTE;
        end else if (c_up == "+") begin
          kind <= K_UNMUTE;
        end else if (c_up == "V") begin
          kind <= K_CQ;
        end else if (c_up == "G") begin
          kind <= K_SIZE;
        end else if (c_up == "A") begin
          kind <= K_AS;
        end else begin
          perr <= 1'b1;
        end
      end else if (c_up == ">" && kind == K_MUTE && nd_out == 2'd0) begin
        kind <= K_LOCK;
      end else if (c_up == "<" && kind == K_UNMUTE && nd_out == 2'd0) begin
        kind <= K_UNLOCK;
      end else if (is_dig && kind == K_SWITCH && !got_at) begin
        // Input number, at most two digits
        num_in <= 7'(num_in * `CRP_TEN + {3'd0, dig});
        nd_in  <= nd_in + 2'd1;
        perr   <= perr || (nd_in == 2'd2);
      end else if (is_dig && kind != K_CQ && kind != K_SIZE) begin
        // Output number, at most two digits
        num_out <= 7'(num_out * `CRP_TEN + {3'd0, dig});
        nd_out  <= nd_out + 2'd1;
        perr    <= perr || (nd_out == 2'd2);
      end else if (c_up == "@" && kind == K_SWITCH && !got_at) begin
        got_at <= 1'b1;
      end else if (c_up == " ") begin
        lay_field <= 1'b1;
      end else if (c_up == "_" && kind == K_AS) begin
        lay_field <= 1'b1;
      end else if (c_up == "=" && kind == K_AS) begin
        lay_field <= 1'b0;
      end else if (c_up == "?" && kind == K_AS) begin
        got_q <= 1'b1;
      end else if (lay_field && c_up == "A") begin
        lay_a <= 1'b1;
      end else if (lay_field && c_up == "V") begin
        lay_v <= 1'b1;
      end else if (!(c_up >= "A" && c_up <= "Z" && (kind == K_CQ || kind == K_SIZE || kind == K_AS))) begin
        // Keyword letters pass, anything else spoils the command
        perr <= 1'b1;
      end
    end
  end

  // Crosspoint, mute and lock state kept per layer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      vid_sel <= 3'd0;
      aud_sel <= 3'd0;
      v_mute  <= 1'b0;
      a_mute  <= 1'b0;
      v_lock  <= 1'b0;
      a_lock  <= 1'b0;
    end else if (state == ST_EXEC && exec_ok) begin
      case (kind)
        K_SWITCH: begin
          // Mute flags untouched; zero input disconnects
          if (lay_v) begin
            vid_sel <= num_in[2:0];
          end
          // Analog video 01/05 pair with analog audio of the same number
          if (lay_a) begin
            aud_sel <= num_in[2:0];
          end
        end
        K_MUTE: begin
          if (eff_v) v_mute <= 1'b1;
          if (eff_a) a_mute <= 1'b1;
        end
        K_UNMUTE: begin
          if (eff_v) v_mute <= 1'b0;
          if (eff_a) a_mute <= 1'b0;
        end
        K_LOCK: begin
          if (eff_v) v_lock <= 1'b1;
          if (eff_a) a_lock <= 1'b1;
        end
        K_UNLOCK: begin
          if (eff_v) v_lock <= 1'b0;
          if (eff_a) a_lock <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // Output enables follow selection and mute
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      vid_active <= 1'b0;
      aud_active <= 1'b0;
    end else begin
      vid_active <= (vid_sel != 3'd0) && !v_mute;
      aud_active <= (aud_sel != 3'd0) && !a_mute;
    end
  end

  // Reply line builder: text is shifted in from the right, first character highest
  always_comb begin
    acc = `CRP_LINE_BITS'("(");
    case (kind)
      K_SWITCH: acc = {acc[71:0], "0", two_dig(num_out), " I", two_dig(num_in)};
      K_MUTE:   acc = {acc[87:0], "1MT", two_dig(num_out)};
      K_UNMUTE: acc = {acc[87:0], "0MT", two_dig(num_out)};
      K_LOCK:   acc = {acc[87:0], "1LO", two_dig(num_out)};
      K_UNLOCK: acc = {acc[87:0], "0LO", two_dig(num_out)};
      K_CQ: begin
        acc = {acc[87:0], "ALL", pend_v ? "V" : "A", " "};
        if (pend_v ? (v_lock && v_mute) : (a_lock && a_mute)) begin
          acc = {acc[119:0], "U"};
        end else if (pend_v ? v_lock : a_lock) begin
          acc = {acc[119:0], "L"};
        end else if (pend_v ? v_mute : a_mute) begin
          acc = {acc[119:0], "M"};
        end
        acc = {acc[111:0], two_dig(pend_v ? {4'd0, vid_sel} : {4'd0, aud_sel})};
      end
      K_SIZE: begin
        acc = {acc[47:0], "SIZE=", `CRP_DIGIT_BASE + 8'(pend_v ? `CRP_VID_INPUTS : `CRP_AUD_INPUTS), "x",
               `CRP_DIGIT_BASE + 8'(`CRP_OUTPUTS), " ", pend_v ? "V" : "A"};
      end
      K_AS: begin
        acc = {acc[63:0], "AS_", lay_v ? "V" : "A", `CRP_DIGIT_BASE + 8'(num_out), "=",
               (lay_v ? autosel[`CRP_AS_V_EN] : autosel[`CRP_AS_A_EN]) ? "E" : "D", ";"};
        case (crp_mode_t'(lay_v ? autosel[`CRP_AS_V_MODE] : autosel[`CRP_AS_A_MODE]))
          MODE_FIRST: acc = {acc[119:0], "F"};
          MODE_LAST:  acc = {acc[119:0], "L"};
          default:    acc = {acc[119:0], "P"};
        endcase
      end
      default: begin
      end
    endcase
    // Layer echo on switch, mute and lock replies
    if (kind == K_SWITCH || kind == K_MUTE || kind == K_UNMUTE || kind == K_LOCK || kind == K_UNLOCK) begin
      if (lay_a && lay_v) begin
        acc = {acc[103:0], " AV"};
      end else if (lay_a || lay_v) begin
        acc = {acc[111:0], " ", lay_v ? "V" : "A"};
      end
    end
    acc = {acc[103:0], ")", `CRP_CR, `CRP_LF};
  end

  // Line length from the kind and its options
  always_comb begin
    case (kind)
      K_SWITCH: llen = 5'd8;
      K_CQ:     llen = 5'd8 + 5'((pend_v ? v_lock || v_mute : a_lock || a_mute) ? 1 : 0);
      K_SIZE:   llen = 5'd11;
      K_AS:     llen = 5'd10;
      default:  llen = 5'd6;
    endcase
    if (kind == K_SWITCH || kind == K_MUTE || kind == K_UNMUTE || kind == K_LOCK || kind == K_UNLOCK) begin
      llen = llen + ((lay_a && lay_v) ? 5'd3 : (lay_a || lay_v) ? 5'd2 : 5'd0);
    end
    llen = llen + 5'd3;
  end

  assign last_idx  = `CRP_LINE_AW'(llen - 5'd1);
  assign wr_char   = acc[{3'd0, `CRP_LINE_AW'(last_idx - wi)} * 7'd8 +: 8];
  assign line_done = (state == ST_SEND) && tx_ready && (ri == last_idx);

  // Line buffer between builder and sender
  crp_line_mem u_line_mem (
    .ref_clk (ref_clk),
    .wr_en   (state == ST_BUILD),
    .wr_addr (wi),
    .wr_data (wr_char),
    .rd_addr (ri),
    .rd_data (mem_rd)
  );

  // Line pointers and pending layer lines
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wi     <= '0;
      ri     <= '0;
      pend_v <= 1'b0;
      pend_a <= 1'b0;
    end else if (state == ST_EXEC) begin
      wi <= '0;
      ri <= '0;
      // State and size queries emit the video line before the audio line
      if (kind == K_CQ || kind == K_SIZE) begin
        pend_v <= eff_v;
        pend_a <= eff_a;
      end else begin
        pend_v <= 1'b0;
        pend_a <= 1'b1;
      end
    end else if (state == ST_BUILD) begin
      wi <= (wi == last_idx) ? '0 : wi + 1'b1;
      ri <= '0;
    end else if (line_done) begin
      ri <= '0;
      if (pend_v) begin
        pend_v <= 1'b0;
      end else begin
        pend_a <= 1'b0;
      end
    end else if (state == ST_SEND && tx_ready) begin
      ri <= ri + 1'b1;
    end
  end

  // Byte stream out
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
    end else if (state == ST_LOAD) begin
      tx_data  <= mem_rd;
      tx_valid <= 1'b1;
    end else if (state == ST_SEND && tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Rejected command count
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rejects <= 16'h0000;
    end else if (state == ST_EXEC && !exec_ok) begin
      rejects <= rejects + 16'h0001;
    end
  end

  // APB: one wait state, then the answer
  assign apb_setup = psel && penable && !pready;
  assign apb_write = psel && penable && pready && pwrite;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apb_setup) begin
        case (paddr)
          `CRP_ADDR_CTRL:    prdata[`CRP_CTRL_EN] <= ctrl_en;
          `CRP_ADDR_AUTOSEL: prdata[`CRP_AS_WIDTH-1:0] <= autosel;
          `CRP_ADDR_STATUS: begin
            prdata[`CRP_ST_V_SEL]  <= vid_sel;
            prdata[`CRP_ST_V_MUTE] <= v_mute;
            prdata[`CRP_ST_V_LOCK] <= v_lock;
            prdata[`CRP_ST_A_SEL]  <= aud_sel;
            prdata[`CRP_ST_A_MUTE] <= a_mute;
            prdata[`CRP_ST_A_LOCK] <= a_lock;
            prdata[`CRP_ST_BUSY]   <= (state != ST_IDLE);
          end
          `CRP_ADDR_REJECTS: prdata[15:0] <= rejects;
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Software settings
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_en <= `CRP_CTRL_RST;
      autosel <= `CRP_AUTOSEL_RST;
    end else if (apb_write && paddr == `CRP_ADDR_CTRL) begin
      ctrl_en <= pwdata[`CRP_CTRL_EN];
    end else if (apb_write && paddr == `CRP_ADDR_AUTOSEL) begin
      autosel <= pwdata[`CRP_AS_WIDTH-1:0];
    end
  end

endmodule : crp_command_handler
`default_nettype wire

// file: core/crp_defs.svh
// Address map, field layout, reset values and fixed counts of the crosspoint command handler
`ifndef CRP_DEFS_SVH
`define CRP_DEFS_SVH

// APB register byte addresses
`define CRP_ADDR_CTRL     12'h000
`define CRP_ADDR_AUTOSEL  12'h004
`define CRP_ADDR_STATUS   12'h008
`define CRP_ADDR_REJECTS  12'h00C

// CTRL layout and reset value
`define CRP_CTRL_EN       0
`define CRP_CTRL_RST      1'b1

// AUTOSEL layout and reset value (both layers disabled, priority detect)
`define CRP_AS_V_EN       0
`define CRP_AS_V_MODE     2:1
`define CRP_AS_A_EN       4
`define CRP_AS_A_MODE     6:5
`define CRP_AS_WIDTH      7
`define CRP_AUTOSEL_RST   7'h44

// STATUS layout
`define CRP_ST_V_SEL      2:0
`define CRP_ST_V_MUTE     3
`define CRP_ST_V_LOCK     4
`define CRP_ST_A_SEL      10:8
`define CRP_ST_A_MUTE     11
`define CRP_ST_A_LOCK     12
`define CRP_ST_BUSY       16

// Crosspoint dimensions and the one output number
`define CRP_VID_INPUTS    7'h06
`define CRP_AUD_INPUTS    7'h05
`define CRP_OUTPUTS       7'h01
`define CRP_OUT_NUM       7'h01

// Character handling
`define CRP_CASE_BIT      8'h20
`define CRP_DIGIT_BASE    8'h30
`define CRP_TEN           7'h0A
`define CRP_CR            8'h0D
`define CRP_LF            8'h0A

// Reply line buffer
`define CRP_LINE_AW       4
`define CRP_LINE_DEPTH    16
`define CRP_LINE_BITS     128

`endif

// file: core/crp_pkg.sv
// Types shared by the crosspoint command handler
package crp_pkg;

  // Controller states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PARSE,
    ST_EXEC,
    ST_BUILD,
    ST_READ,
    ST_LOAD,
    ST_SEND
  } crp_state_t;

  // Recognised command kinds
  typedef enum logic [3:0] {
    K_NONE,
    K_SWITCH,
    K_MUTE,
    K_UNMUTE,
    K_LOCK,
    K_UNLOCK,
    K_CQ,
    K_SIZE,
    K_AS
  } crp_kind_t;

  // Automatic source selection modes
  typedef enum logic [1:0] {
    MODE_FIRST,
    MODE_LAST,
    MODE_PRIO
  } crp_mode_t;

endpackage : crp_pkg

// file: core/crp_line_mem.sv
// Small reply line buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "crp_defs.svh"

module crp_line_mem
  import crp_pkg::*;
(
  // Clock
  input  wire logic                     ref_clk,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [`CRP_LINE_AW-1:0]  wr_addr,
  input  wire logic [7:0]               wr_data,
  // Read port
  input  wire logic [`CRP_LINE_AW-1:0]  rd_addr,
  output var  logic [7:0]               rd_data
);

  // Character storage
  logic [7:0] mem [`CRP_LINE_DEPTH];

  // Write one character
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read
  always_ff @(posedge ref_clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : crp_line_mem
`default_nettype wire

// file: dv/crp_command_handler_properties.sv
// Port-level properties of the crosspoint command handler
`timescale 1ns/1ps
`default_nettype none
module crp_cmd_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // APB handshake
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // Command and reply streams
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic       rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  // Crosspoint controls
  input wire logic [2:0] vid_sel,
  input wire logic       vid_active,
  input wire logic [2:0] aud_sel,
  input wire logic       aud_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Exactly one wait state on every access
  AST_APB_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("APB answer not after one wait");
  AST_VID_OFF: assert property ($stable(vid_sel) && vid_sel == 3'h0 |-> !vid_active)
    else $error("Video active while disconnected");
  AST_AUD_OFF: assert property ($stable(aud_sel) && aud_sel == 3'h0 |-> !aud_active)
    else $error("Audio active while disconnected");
  AST_CR_AFTER_PAREN: assert property (tx_valid && tx_ready && tx_data == 8'h29 |=> ##[0:3] (tx_valid && tx_data == 8'h0D))
    else $error("No CR after reply");
  AST_LF_AFTER_CR: assert property (tx_valid && tx_ready && tx_data == 8'h0D |=> ##[0:3] (tx_valid && tx_data == 8'h0A))
    else $error("No LF after CR");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("Reply byte dropped");
  AST_RX_BUSY: assert property ($fell(rx_ready) |-> $past(rx_valid && rx_data == 8'h7D))
    else $error("Input closed without close bracket");
  AST_QUIET_IDLE: assert property (rx_ready |-> !tx_valid)
    else $error("Reply without command");
  AST_SEL_RANGE: assert property (vid_sel <= 3'h6 && aud_sel <= 3'h5)
    else $error("Selection out of range");
endmodule : crp_cmd_props
bind crp_command_handler crp_cmd_props u_props (.*);
`default_nettype wire

// file: dv/crp_host_model.sv
// Remote controller: sends commands, gathers replies
`timescale 1ns/1ps
`default_nettype none
module crp_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Commands out
  output var  logic [7:0] rx_data,
  output var  logic       rx_valid,
  input  wire logic       rx_ready,
  // Replies in
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output var  logic       tx_ready
);
  string rsp  = "";  // Reply text so far
  bit    slow = 0;   // Stall replies
  int    errs = 0;   // Stuck handshakes
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // One byte at a time, held until taken
  task automatic send(input string s);
    int n;
    for (int i = 0; i < s.len(); i++) begin
      rx_data  <= s[i];
      rx_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge ref_clk);
        n++;
      end while (rx_ready !== 1'b1 && n < 100);
      if (n >= 100) errs++;
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;  // No stale byte after release
  endtask : send
  // Reply sink, every other cycle when slow
  always @(posedge ref_clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) rsp = {rsp, string'(tx_data)};
  end
endmodule : crp_host_model
`default_nettype wire

// file: dv/crp_command_handler_tb.sv
// Self-checking bench for the crosspoint command handler
`timescale 1ns/1ps
`default_nettype none
module crp_command_handler_tb;
  // Command, reply, selections, active flags
  typedef struct {
    string      cmd;
    string      rsp;
    logic [2:0] vs;
    logic [2:0] as;
    logic       va;
    logic       aa;
  } crp_row_t;
  logic        ref_clk = 1'b0;           // Clock
  logic        reset   = 1'b1;           // Reset
  logic        psel    = 1'b0;           // APB request
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata, rd;               // Read data
  logic        pready, pslverr, er;
  logic [7:0]  rx_data, tx_data;         // Streams
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic [2:0]  vid_sel, aud_sel;         // Crosspoint
  logic        vid_active, aud_active;
  int          bad_count = 0;            // Mismatches
  int          compares  = 0;            // Checks made
  crp_row_t    rows[20] = '{
    '{"{2@1 AV}", "(001 I02 AV)\r\n", 3'h2, 3'h2, 1'h1, 1'h1},
    '{"{1@1 AV}", "(001 I01 AV)\r\n", 3'h1, 3'h1, 1'h1, 1'h1},
    '{"{5@1 av}", "(001 I05 AV)\r\n", 3'h5, 3'h5, 1'h1, 1'h1},
    '{"{#1 A}", "(1MT01 A)\r\n", 3'h5, 3'h5, 1'h1, 1'h0},
    '{"{3@1 A}", "(001 I03 A)\r\n", 3'h5, 3'h3, 1'h1, 1'h0},
    '{"{+1}", "(0MT01)\r\n", 3'h5, 3'h3, 1'h1, 1'h1},
    '{"{#1}", "(1MT01)\r\n", 3'h5, 3'h3, 1'h0, 1'h0},
    '{"{#>1 V}", "(1LO01 V)\r\n", 3'h5, 3'h3, 1'h0, 1'h0},
    '{"{0@1 V}", "", 3'h5, 3'h3, 1'h0, 1'h0},
    '{"{vc av}", "(ALLV U05)\r\n(ALLA M03)\r\n", 3'h5, 3'h3, 1'h0, 1'h0},
    '{"{+<1}", "(0LO01)\r\n", 3'h5, 3'h3, 1'h0, 1'h0},
    '{"{+1}", "(0MT01)\r\n", 3'h5, 3'h3, 1'h1, 1'h1},
    '{"{#>1 A}", "(1LO01 A)\r\n", 3'h5, 3'h3, 1'h1, 1'h1},
    '{"{vc a}", "(ALLA L03)\r\n", 3'h5, 3'h3, 1'h1, 1'h1},
    '{"{0@1 V}", "(001 I00 V)\r\n", 3'h0, 3'h3, 1'h0, 1'h1},
    '{"{6@1 AV}", "", 3'h0, 3'h3, 1'h0, 1'h1},
    '{"{6@1 V}", "(001 I06 V)\r\n", 3'h6, 3'h3, 1'h1, 1'h1},
    '{"{getsize av}", "(SIZE=6x1 V)\r\n(SIZE=5x1 A)\r\n", 3'h6, 3'h3, 1'h1, 1'h1},
    '{"{as_v1=?}", "(AS_V1=E;F)\r\n", 3'h6, 3'h3, 1'h1, 1'h1},
    '{"{as_a1=?}", "(AS_A1=D;L)\r\n", 3'h6, 3'h3, 1'h1, 1'h1}};
  always #50 ref_clk = ~ref_clk;
  crp_command_handler DUT (.*);
  crp_host_model host (.*);
  // Counts, verdict, end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // Value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Reply text compare
  task automatic chs(input string nm, input string e);
    compares++;
    if (e != host.rsp) begin
      bad_count++;
      $display("[FAIL] %s expected %s seen %s", nm, e, host.rsp);
    end
  endtask : chs
  // Bounded wait on a level
  task automatic hold(ref logic s, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (s !== 1'b1 && n < lim);
    if (n >= lim) begin
      bad_count++;
      wrap_up();
    end
  endtask : hold
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    hold(pready, 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Command, then wait for the handler to reopen
  task automatic cmd(input string c);
    host.rsp = "";
    @(posedge ref_clk);
    host.send(c);
    hold(rx_ready, 500);
    repeat (2) @(posedge ref_clk);
  endtask : cmd
  initial begin
    repeat (5) @(posedge ref_clk);
    chk("rst rx_ready", 1'h0, rx_ready);
    chk("rst vid_sel", 3'h0, vid_sel);
    repeat (15) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("CTRL", 32'h0000_0001, rd);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("AUTOSEL", 32'h0000_0044, rd);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped", 1'h1, er);
    apb(1'b1, 12'h004, 32'h0000_0021);
    apb(1'b1, 12'h000, 32'h0000_0000);
    cmd("{1@1 V}");
    chs("disabled", "");
    apb(1'b1, 12'h000, 32'h0000_0001);
    $display("reset and registers done");
    for (int i = 0; i < 20; i++) begin
      host.slow = i[0];
      cmd(rows[i].cmd);
      chs(rows[i].cmd, rows[i].rsp);
      chk("vid_sel", rows[i].vs, vid_sel);
      chk("aud_sel", rows[i].as, aud_sel);
      chk("vid_active", rows[i].va, vid_active);
      chk("aud_active", rows[i].aa, aud_active);
      $display("row %0d done", i);
    end
    apb(1'b1, 12'h004, 32'h0000_0044);
    cmd("{as_a1=?}");
    chs("prio", "(AS_A1=D;P)\r\n");
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("REJECTS", 32'h0000_0002, rd);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("STATUS", 32'h0000_1306, rd);
    chk("host", 32'h0000_0000, host.errs);
    $display("awkward cases done");
    wrap_up();
  end
endmodule : crp_command_handler_tb
`default_nettype wire
